/* include/sha1de_defines.svh */
// constants for the sha-1 digest engine and its message source
`ifndef SHA1DE_DEFINES_SVH
`define SHA1DE_DEFINES_SVH

// ****************************************
// block geometry and round counts
// ****************************************
`define SHA1DE_WORD_W 32
`define SHA1DE_SLOT_LAST 7'h0f
`define SHA1DE_LEN_HI_SLOT 4'he
`define SHA1DE_LEN_LO_SLOT 4'hf
`define SHA1DE_ROUND_LAST 7'h4f
`define SHA1DE_ROUND_STAGE1 7'h14
`define SHA1DE_ROUND_STAGE2 7'h28
`define SHA1DE_ROUND_STAGE3 7'h3c
`define SHA1DE_FULL_BYTES 2'h3
`define SHA1DE_WORD_BITS 64'h0000000000000020

// ****************************************
// reset values and pad words
// ****************************************
`define SHA1DE_DIGEST_RST 32'h00000000
`define SHA1DE_ZERO_WORD 32'h00000000
`define SHA1DE_PAD_WORD 32'h80000000

// ****************************************
// initial chaining values and round constants
// ****************************************
`define SHA1DE_IV0 32'h67452301
`define SHA1DE_IV1 32'hefcdab89
`define SHA1DE_IV2 32'h98badcfe
`define SHA1DE_IV3 32'h10325476
`define SHA1DE_IV4 32'hc3d2e1f0
`define SHA1DE_K0 32'h5a827999
`define SHA1DE_K1 32'h6ed9eba1
`define SHA1DE_K2 32'h8f1bbcdc
`define SHA1DE_K3 32'hca62c1d6

`endif

/* include/sha1de_pkg.sv */
// types shared by both ends of the sha-1 digest link
package sha1de_pkg;

  typedef logic [31:0] sha1de_word_t;
  typedef logic [4:0][31:0] sha1de_digest_t;

  typedef enum logic [2:0] {
    SHA1DE_IDLE,
    SHA1DE_INPUT,
    SHA1DE_PAD,
    SHA1DE_COMPRESS,
    SHA1DE_ADD,
    SHA1DE_FINISH,
    SHA1DE_DONE
  } sha1de_state_t;

endpackage : sha1de_pkg

/* include/sha1de_if.sv */
// link between the message source and the sha-1 digest engine
`timescale 1ns/1ps
interface sha1de_if;
  import sha1de_pkg::*;

  logic en;
  logic start;
  sha1de_word_t din;
  logic ack;
  logic last;
  logic [1:0] bytes;
  logic req;
  logic ready;
  sha1de_word_t digest_word_a;
  sha1de_word_t digest_word_b;
  sha1de_word_t digest_word_c;
  sha1de_word_t digest_word_d;
  sha1de_word_t digest_word_e;

  modport dev (
    input en, start, din, ack, last, bytes,
    output req, ready, digest_word_a, digest_word_b, digest_word_c, digest_word_d,
    digest_word_e
  );

  modport src (
    output en, start, din, ack, last, bytes,
    input req, ready, digest_word_a, digest_word_b, digest_word_c, digest_word_d,
    digest_word_e
  );

endinterface : sha1de_if

/* src/sha1de_engine.sv */
// sha-1 digest engine: word intake, padding, 80-round compression, digest output
// Overview of operation
// - reset acts asynchronously on low async_clear_n
// - reset clears req, ready and digest words
// - enable low freezes every register and input
// - start pulse reinitialises running digest and length count
// - req high only when a word fits
// - word taken on edge with req and ack
// - ack low with req high stalls engine
// - ack ignored while req is low
// - req drops after sixteen words for compression
// - req returns 65 cycles after block end
// - 512-bit blocks, 160-bit digest of five words
// - block result added word-wise into running digest
// - last flag marks the final message word
// - bytes code is valid bytes minus one, from top
// - any byte length, bytes used on last only
// - at least one pad byte, zero fill
// - engine appends two 32-bit bit-length words
// - padding after last word takes one cycle per slot left in the block
// - ready with digest 66 clocks after padding
// - ready holds until start or reset, digest until the next result or reset
`timescale 1ns/1ps
`include "sha1de_defines.svh"
module sha1de_engine
  import sha1de_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic async_clear_n,
  // link to the message source
  sha1de_if.dev lnk
);

  // ****************************************
  // helper functions
  // ****************************************
  // final word masked to its valid bytes with the 0x80 pad byte behind them unless all four bytes are valid
  function automatic sha1de_word_t last_word(input sha1de_word_t d, input logic [1:0] n);
    sha1de_word_t r;
    r = d;
    unique case (n)
      2'h0: r = {d[31:24], 24'h800000};
      2'h1: r = {d[31:16], 16'h8000};
      2'h2: r = {d[31:8], 8'h80};
      2'h3: r = d;
    endcase
    return r;
  endfunction : last_word

  function automatic sha1de_word_t round_f(input logic [6:0] t, input sha1de_word_t b,
                                           input sha1de_word_t c, input sha1de_word_t d);
    sha1de_word_t r;
    if (t < `SHA1DE_ROUND_STAGE1)
      r = (b & c) | (~b & d);
    else if (t < `SHA1DE_ROUND_STAGE2 || t >= `SHA1DE_ROUND_STAGE3)
      r = b ^ c ^ d;
    else
      r = (b & c) | (b & d) | (c & d);
    return r;
  endfunction : round_f

  function automatic sha1de_word_t round_k(input logic [6:0] t);
    sha1de_word_t r;
    if (t < `SHA1DE_ROUND_STAGE1)
      r = `SHA1DE_K0;
    else if (t < `SHA1DE_ROUND_STAGE2)
      r = `SHA1DE_K1;
    else if (t < `SHA1DE_ROUND_STAGE3)
      r = `SHA1DE_K2;
    else
      r = `SHA1DE_K3;
    return r;
  endfunction : round_k

  // ****************************************
  // state
  // ****************************************
  sha1de_state_t state_reg;
  sha1de_state_t state_next;
  logic [6:0] rnd_reg;
  logic [6:0] rnd_next;
  logic [63:0] bitlen_reg;
  logic [63:0] bitlen_next;
  logic final_reg;
  logic final_next;
  logic pad_done_reg;
  logic pad_done_next;
  logic len_mode_reg;
  logic len_mode_next;
  logic req_reg;
  logic ready_reg;
  logic ready_next;
  sha1de_digest_t h_reg;
  sha1de_digest_t h_next;
  sha1de_digest_t v_reg;
  sha1de_digest_t v_next;
  sha1de_digest_t dig_reg;
  sha1de_digest_t dig_next;
  sha1de_word_t w_mem [16];

  // ****************************************
  // decode
  // ****************************************
  wire in_state = (state_reg == SHA1DE_INPUT);
  wire pad_state = (state_reg == SHA1DE_PAD);
  wire comp_state = (state_reg == SHA1DE_COMPRESS);
  wire take = in_state & req_reg & lnk.ack;
  wire take_last = take & lnk.last;
  wire round_go = take | pad_state | comp_state;
  wire slot_end = (rnd_reg == `SHA1DE_SLOT_LAST);
  wire round_end = (rnd_reg == `SHA1DE_ROUND_LAST);
  wire [3:0] slot = rnd_reg[3:0];

  // pad byte first, zeros, then length high and low in the last two slots
  wire len_hi_now = pad_done_reg & (slot == `SHA1DE_LEN_HI_SLOT);
  wire len_lo_now = len_mode_reg & (slot == `SHA1DE_LEN_LO_SLOT);
  wire sha1de_word_t pad_word = !pad_done_reg ? `SHA1DE_PAD_WORD :
                                len_hi_now ? bitlen_reg[63:32] :
                                len_lo_now ? bitlen_reg[31:0] :
                                `SHA1DE_ZERO_WORD;
  // bytes is only looked at on the final word
  wire sha1de_word_t in_word = lnk.last ? last_word(lnk.din, lnk.bytes) : lnk.din;
  wire sha1de_word_t sched_word = w_mem[slot + 4'hd] ^ w_mem[slot + 4'h8] ^
                                  w_mem[slot + 4'h2] ^ w_mem[slot];
  wire sha1de_word_t w_cur = comp_state ? {sched_word[30:0], sched_word[31]} :
                             pad_state ? pad_word : in_word;
  // widened before the add, so a full last word counts four bytes, not zero
  wire [63:0] add_bits = lnk.last ? {58'h0, {1'b0, lnk.bytes} + 3'h1, 3'h0} : `SHA1DE_WORD_BITS;

  // one round per accepted word, so only 64 rounds remain after a block
  wire sha1de_word_t temp = {v_reg[0][26:0], v_reg[0][31:27]} +
                            round_f(rnd_reg, v_reg[1], v_reg[2], v_reg[3]) +
                            v_reg[4] + round_k(rnd_reg) + w_cur;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    rnd_next = rnd_reg;
    bitlen_next = bitlen_reg;
    final_next = final_reg;
    pad_done_next = pad_done_reg;
    len_mode_next = len_mode_reg;
    ready_next = ready_reg;
    h_next = h_reg;
    v_next = v_reg;
    dig_next = dig_reg;
    if (lnk.start)
    begin
      state_next = SHA1DE_INPUT;
      rnd_next = 7'h00;
      bitlen_next = 64'h0;
      final_next = 1'b0;
      pad_done_next = 1'b0;
      len_mode_next = 1'b0;
      ready_next = 1'b0;
      h_next = {`SHA1DE_IV4, `SHA1DE_IV3, `SHA1DE_IV2, `SHA1DE_IV1, `SHA1DE_IV0};
      v_next = h_next;
    end
    else
    begin
      if (round_go)
      begin
        v_next = {v_reg[3], v_reg[2], {v_reg[1][1:0], v_reg[1][31:2]}, v_reg[0], temp};
        rnd_next = round_end ? 7'h00 : rnd_reg + 7'h01;
      end
      if (take)
      begin
        bitlen_next = bitlen_reg + add_bits;
        final_next = lnk.last;
        pad_done_next = take_last & (lnk.bytes != `SHA1DE_FULL_BYTES);
      end
      if (pad_state)
      begin
        pad_done_next = 1'b1;
        len_mode_next = len_mode_reg | len_hi_now;
      end
      unique case (state_reg)
        SHA1DE_IDLE, SHA1DE_DONE:
          state_next = state_reg;
        SHA1DE_INPUT:
          if (take & slot_end)
            state_next = SHA1DE_COMPRESS;
          else if (take_last)
            state_next = SHA1DE_PAD;
        SHA1DE_PAD:
          if (slot_end)
            state_next = SHA1DE_COMPRESS;
        SHA1DE_COMPRESS:
          if (round_end)
            state_next = SHA1DE_ADD;
        SHA1DE_ADD:
        begin
          for (int i = 0; i < 5; i++)
            h_next[i] = h_reg[i] + v_reg[i];
          v_next = h_next;
          // length not yet placed means one more all-pad block
          state_next = !final_reg ? SHA1DE_INPUT :
                       len_mode_reg ? SHA1DE_FINISH : SHA1DE_PAD;
        end
        SHA1DE_FINISH:
        begin
          dig_next = h_reg;
          ready_next = 1'b1;
          state_next = SHA1DE_DONE;
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // enable low freezes everything, including the round pipeline
  always_ff @(posedge core_clk or negedge async_clear_n)
  begin
    if (!async_clear_n)
    begin
      state_reg <= SHA1DE_IDLE;
      rnd_reg <= 7'h00;
      bitlen_reg <= 64'h0;
      final_reg <= 1'b0;
      pad_done_reg <= 1'b0;
      len_mode_reg <= 1'b0;
      req_reg <= 1'b0;
      ready_reg <= 1'b0;
      h_reg <= '0;
      v_reg <= '0;
      dig_reg <= {5{`SHA1DE_DIGEST_RST}};
    end
    else if (lnk.en)
    begin
      state_reg <= state_next;
      rnd_reg <= rnd_next;
      bitlen_reg <= bitlen_next;
      final_reg <= final_next;
      pad_done_reg <= pad_done_next;
      len_mode_reg <= len_mode_next;
      req_reg <= (state_next == SHA1DE_INPUT);
      ready_reg <= ready_next;
      h_reg <= h_next;
      v_reg <= v_next;
      dig_reg <= dig_next;
    end
  end

  // schedule memory holds no control state, so it needs no reset
  always_ff @(posedge core_clk)
  begin
    if (lnk.en && round_go && !lnk.start)
      w_mem[slot] <= w_cur;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign lnk.req = req_reg;
  assign lnk.ready = ready_reg;
  assign lnk.digest_word_a = dig_reg[0];
  assign lnk.digest_word_b = dig_reg[1];
  assign lnk.digest_word_c = dig_reg[2];
  assign lnk.digest_word_d = dig_reg[3];
  assign lnk.digest_word_e = dig_reg[4];

endmodule : sha1de_engine

/* src/sha1de_source.sv */
// message source: feeds words to the digest engine and collects the digest
`timescale 1ns/1ps
`include "sha1de_defines.svh"
module sha1de_source
  import sha1de_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic async_clear_n,
  // user control
  input wire logic usr_enable,
  input wire logic usr_start,
  // user words
  input wire logic usr_valid,
  input wire sha1de_word_t usr_data,
  input wire logic usr_last,
  input wire logic [1:0] usr_bytes,
  output logic usr_ready,
  // result
  output logic usr_done,
  output sha1de_digest_t usr_digest,
  // link to the engine
  sha1de_if.src lnk
);

  logic en_reg;
  logic start_reg;
  logic hold_reg;
  logic hold_next;
  sha1de_word_t data_reg;
  logic last_reg;
  logic [1:0] bytes_reg;
  logic ready_q_reg;
  logic done_reg;
  sha1de_digest_t digest_reg;

  // ****************************************
  // handshake decode
  // ****************************************
  wire taken = en_reg & lnk.req & hold_reg;
  wire load = usr_valid & usr_ready;
  wire ready_rise = lnk.ready & !ready_q_reg;
  // a start drops any word still held, it belongs to the old message
  assign hold_next = !usr_start & (load | (hold_reg & !taken));

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk or negedge async_clear_n)
  begin
    if (!async_clear_n)
    begin
      en_reg <= 1'b0;
      start_reg <= 1'b0;
      hold_reg <= 1'b0;
      data_reg <= `SHA1DE_ZERO_WORD;
      last_reg <= 1'b0;
      bytes_reg <= 2'h0;
      usr_ready <= 1'b0;
      ready_q_reg <= 1'b0;
      done_reg <= 1'b0;
      digest_reg <= {5{`SHA1DE_DIGEST_RST}};
    end
    else
    begin
      en_reg <= usr_enable;
      start_reg <= usr_start;
      hold_reg <= hold_next;
      usr_ready <= !hold_next & !usr_start;
      if (load)
      begin
        // last and bytes travel with their word
        data_reg <= usr_data;
        last_reg <= usr_last;
        bytes_reg <= usr_bytes;
      end
      ready_q_reg <= lnk.ready;
      done_reg <= ready_rise;
      if (ready_rise)
        digest_reg <= {lnk.digest_word_e, lnk.digest_word_d, lnk.digest_word_c,
                       lnk.digest_word_b, lnk.digest_word_a};
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign lnk.en = en_reg;
  assign lnk.start = start_reg;
  assign lnk.din = data_reg;
  assign lnk.ack = hold_reg;
  assign lnk.last = last_reg;
  assign lnk.bytes = bytes_reg;
  assign usr_done = done_reg;
  assign usr_digest = digest_reg;

endmodule : sha1de_source

/* verification/sha1de_link_sva.sv */
// assertions on the link between the message source and the sha-1 digest engine
`timescale 1ns/1ps
module sha1de_link_sva
  import sha1de_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic async_clear_n,
  // source side
  input wire logic en,
  input wire logic start,
  input wire logic ack,
  input wire logic last,
  input wire logic [1:0] bytes,
  // engine side
  input wire logic req,
  input wire logic ready,
  input wire sha1de_word_t digest_word_a,
  input wire sha1de_word_t digest_word_b,
  input wire sha1de_word_t digest_word_c,
  input wire sha1de_word_t digest_word_d,
  input wire sha1de_word_t digest_word_e
);
  // ****************************************
  // helper counters
  // ****************************************
  logic [3:0] slot_reg;
  logic [6:0] gap_reg;
  logic [7:0] due_reg;
  logic [7:0] tgt_reg;
  wire go = en && start;
  wire take = en && req && ack && !start;
  wire blk_end = take && slot_reg == 4'hf && !last;
  // a final word that pushes the pad into an extra block is not timed here
  wire fin_short = take && last && (slot_reg < 4'hd || (slot_reg == 4'hd && bytes != 2'h3));
  wire [159:0] dig = {digest_word_a, digest_word_b, digest_word_c, digest_word_d, digest_word_e};

  always_ff @(posedge core_clk or negedge async_clear_n)
  begin
    if (!async_clear_n)
    begin
      slot_reg <= 4'h0;
      gap_reg <= 7'h00;
      due_reg <= 8'h00;
      tgt_reg <= 8'h00;
    end
    else if (go)
    begin
      slot_reg <= 4'h0;
      gap_reg <= 7'h00;
      due_reg <= 8'h00;
    end
    else
    begin
      if (take) slot_reg <= slot_reg + 4'h1;
      // counts pause with enable, as the engine does
      if (blk_end) gap_reg <= 7'h01;
      else if (gap_reg == 7'h42) gap_reg <= 7'h00;
      else if (gap_reg != 7'h00 && en) gap_reg <= gap_reg + 7'h01;
      if (fin_short) due_reg <= 8'h01;
      else if (due_reg == tgt_reg) due_reg <= 8'h00;
      else if (due_reg != 8'h00 && en) due_reg <= due_reg + 8'h01;
      if (fin_short) tgt_reg <= 8'h52 - {4'h0, slot_reg};
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!async_clear_n);

  a_reset_clears_outputs: assert property (disable iff (1'b0)
    !async_clear_n |-> !req && !ready && dig == 160'h0) else $error("outputs not cleared in reset");
  a_disable_freezes: assert property (!en |=> $stable(req) && $stable(ready) && $stable(dig))
    else $error("state moved while disabled");
  a_start_requests: assert property (go |=> req && !ready)
    else $error("start did not open word intake");
  a_stall_holds_req: assert property (en && req && !ack && !start |=> req)
    else $error("request dropped during stall");
  a_done_no_req: assert property (ready |-> !req)
    else $error("request while digest shown");
  a_req_low_compress: assert property (gap_reg != 7'h00 && gap_reg < 7'h42 |-> !req)
    else $error("request during compression");
  a_req_returns: assert property (gap_reg == 7'h42 |-> req)
    else $error("request not back after block");
  a_ready_not_early: assert property (due_reg != 8'h00 && due_reg < tgt_reg |-> !ready)
    else $error("digest valid too early");
  a_ready_on_time: assert property (due_reg != 8'h00 && due_reg == tgt_reg |-> ready)
    else $error("digest valid late");
  a_result_holds: assert property (ready && !go |=> ready && $stable(dig))
    else $error("digest changed while valid");

  c_digest_ready: cover property ($rose(ready));
  c_block_gap: cover property (gap_reg == 7'h42);
  c_freeze: cover property (!en && gap_reg != 7'h00);
  c_restart: cover property (go && ready);
endmodule : sha1de_link_sva

/* verification/tb_sha1_digest_engine.sv */
// self-checking testbench joining the message source and the digest engine
`timescale 1ns/1ps
`define CHECK(got, want) \
  begin \
    num_checks++; \
    if ((got) !== (want)) \
    begin \
      bad_count++; \
      $display("Error at %0t: value %h differs from %h", $time, got, want); \
    end \
  end
module tb_sha1_digest_engine
  import sha1de_pkg::*;
;
  logic core_clk = 1'b0;
  logic async_clear_n, usr_enable, usr_start, usr_valid, usr_last, usr_ready, usr_done;
  sha1de_word_t usr_data;
  logic [1:0] usr_bytes;
  sha1de_digest_t usr_digest;
  int bad_count = 0;
  int num_checks = 0;
  sha1de_word_t msg_q[$];
  logic [159:0] exp_tab [4];

  always #2.5 core_clk = ~core_clk;

  // ****************************************
  // both ends and the checker
  // ****************************************
  sha1de_if sha1de_if_i ();
  sha1de_engine sha1de_engine_i (.core_clk(core_clk), .async_clear_n(async_clear_n),
    .lnk(sha1de_if_i));
  sha1de_source sha1de_source_i (.core_clk(core_clk), .async_clear_n(async_clear_n),
    .usr_enable(usr_enable), .usr_start(usr_start), .usr_valid(usr_valid),
    .usr_data(usr_data), .usr_last(usr_last), .usr_bytes(usr_bytes), .usr_ready(usr_ready),
    .usr_done(usr_done), .usr_digest(usr_digest), .lnk(sha1de_if_i));
  sha1de_link_sva sha1de_link_sva_i (.core_clk(core_clk), .async_clear_n(async_clear_n),
    .en(sha1de_if_i.en), .start(sha1de_if_i.start), .ack(sha1de_if_i.ack),
    .last(sha1de_if_i.last), .bytes(sha1de_if_i.bytes), .req(sha1de_if_i.req),
    .ready(sha1de_if_i.ready), .digest_word_a(sha1de_if_i.digest_word_a),
    .digest_word_b(sha1de_if_i.digest_word_b), .digest_word_c(sha1de_if_i.digest_word_c),
    .digest_word_d(sha1de_if_i.digest_word_d), .digest_word_e(sha1de_if_i.digest_word_e));

  // ****************************************
  // tasks
  // ****************************************
  function automatic logic [159:0] cur_dig();
    return {sha1de_if_i.digest_word_a, sha1de_if_i.digest_word_b, sha1de_if_i.digest_word_c,
      sha1de_if_i.digest_word_d, sha1de_if_i.digest_word_e};
  endfunction : cur_dig

  // source result, reordered so word a leads as on the link
  function automatic logic [159:0] usr_dig();
    return {usr_digest[0], usr_digest[1], usr_digest[2], usr_digest[3], usr_digest[4]};
  endfunction : usr_dig

  task results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task give_up(input string what);
    bad_count++;
    $display("Error at %0t: %s timed out", $time, what);
    results();
  endtask : give_up

  task begin_msg();
    usr_start <= 1'b1;
    @(posedge core_clk);
    usr_start <= 1'b0;
  endtask : begin_msg

  // valid stays up between words so it is never driven twice in one step
  task send_word(input sha1de_word_t d, input logic l, input logic [1:0] b);
    int n;
    usr_valid <= 1'b1;
    usr_data <= d;
    usr_last <= l;
    usr_bytes <= b;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (usr_ready !== 1'b1 && n < 400);
    if (n >= 400) give_up("word");
  endtask : send_word

  task send_msg(input logic [1:0] b);
    foreach (msg_q[i])
      send_word(msg_q[i], i == msg_q.size() - 1, b);
    usr_valid <= 1'b0;
  endtask : send_msg

  task check_digest(input logic [159:0] want);
    int n;
    n = 0;
    while (sha1de_if_i.ready !== 1'b1 && n < 400)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 400) give_up("digest");
    `CHECK(cur_dig(), want)
    // done pulses for one cycle, one edge after ready rises
    @(posedge core_clk);
    `CHECK(usr_done, 1'b1)
    `CHECK(usr_dig(), want)
  endtask : check_digest

  // letter runs: stride 1 or interleaved runs of eight
  task build_msg(input int n, input bit wide);
    logic [7:0] c;
    msg_q.delete();
    for (int j = 0; j < n; j++)
    begin
      c = wide ? 8'h61 + 8'(j / 2 + (j % 2) * 4) : 8'h61 + 8'(j);
      msg_q.push_back({c, c + 8'h01, c + 8'h02, c + 8'h03});
    end
  endtask : build_msg

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    async_clear_n = 1'b1;
    usr_enable = 1'b0;
    usr_start = 1'b0;
    usr_valid = 1'b0;
    usr_data = 32'h00000000;
    usr_last = 1'b0;
    usr_bytes = 2'h0;
    // a real falling edge, so the asynchronous clear acts before the first clock
    #1;
    async_clear_n = 1'b0;
    exp_tab[0] = 160'h86f7e437faa5a7fce15d1ddcb9eaeaea377667b8;
    exp_tab[1] = 160'hda23614e02469a0d7c7bd1bdab5c9c474b1904dc;
    exp_tab[2] = 160'ha9993e364706816aba3e25717850c26c9cd0d89d;
    exp_tab[3] = 160'h81fe8bfe87576c3ecb22426f8e57847382917acf;
    repeat (16) @(posedge core_clk);
    `CHECK(sha1de_if_i.req, 1'b0)
    `CHECK(cur_dig(), 160'h0)
    async_clear_n <= 1'b1;
    usr_enable <= 1'b1;
    @(posedge core_clk);
    // junk below the valid bytes must not reach the hash
    for (int k = 0; k < 4; k++)
    begin
      begin_msg();
      msg_q = {32'h61626364};
      send_msg(2'(k));
      check_digest(exp_tab[k]);
    end
    repeat (20) @(posedge core_clk);
    `CHECK(sha1de_if_i.ready, 1'b1)
    `CHECK(cur_dig(), exp_tab[3])
    begin_msg();
    send_word(32'h11111111, 1'b0, 2'h3);
    send_word(32'h22222222, 1'b0, 2'h0);
    usr_valid <= 1'b0;
    repeat (4) @(posedge core_clk);
    begin_msg();
    msg_q = {32'h54686520, 32'h71756963, 32'h6b206272, 32'h6f776e20, 32'h666f7820,
      32'h6a756d70, 32'h73206f76, 32'h65722074, 32'h6865206c, 32'h617a7920, 32'h646f67aa};
    send_msg(2'h2);
    check_digest(160'h2fd4e1c67a2d28fced849ee1bb76e7391b93eb12);
    build_msg(14, 1'b0);
    begin_msg();
    send_msg(2'h3);
    check_digest(160'h84983e441c3bd26ebaae4aa1f95129e5e54670f1);
    build_msg(28, 1'b1);
    begin_msg();
    fork
      begin
        repeat (60) @(posedge core_clk);
        usr_enable <= 1'b0;
        repeat (12) @(posedge core_clk);
        usr_enable <= 1'b1;
      end
    join_none
    send_msg(2'h3);
    check_digest(160'ha49b2446a02c645bf419f995b67091253a04a259);
    @(posedge core_clk);
    async_clear_n <= 1'b0;
    #1;
    `CHECK(sha1de_if_i.ready, 1'b0)
    `CHECK(cur_dig(), 160'h0)
    repeat (4) @(posedge core_clk);
    async_clear_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    `CHECK(sha1de_if_i.req, 1'b0)
    `CHECK(usr_done, 1'b0)
    results();
  end
endmodule : tb_sha1_digest_engine
